// [ram_pkg.sv]
// Purpose: constants shared by the register access error monitor
// Assumes: 32-bit AXI4-Lite register window, one aligned word per register
// Notes: all reset values are zero, meaning nothing recorded yet
// Summary of operation
// R1: unknown target sets flag bit8, ID bits7:0
// R2: ignored request sets flag bit24, ID bits23:16
// R3: dropped busy request sets busy flag bit8
// R4: busy ID holds most recent busy target
// R5: writing all ones clears busy register
// R6: count ignored requests in bits 31:24
// R7: count unknown-target requests in bits 23:16
// R8: count busy-dropped requests in bits 15:8
// R9: failure counters saturate, never wrap
// R10: read starting before previous completes sets bit1
// R11: overlapping reads both run, latest data wins
// R12: in-progress bit0 high while access outstanding
// R13: flags, IDs, counters reset to zero
// R14: flags stay until cleared; counters writable
package ram_pkg;
	localparam int ADDR_W = 6;
	localparam int DATA_W = 32;
	localparam int ID_W = 8;
	localparam int CNT_W = 8;
	localparam int ACC_CNT_W = 4;
	localparam int IRQ_W = 4;

	localparam logic [ADDR_W-1:0] OFS_ERR_DROP = 6'h00;
	localparam logic [ADDR_W-1:0] OFS_BUSY_ERR = 6'h08;
	localparam logic [ADDR_W-1:0] OFS_FAILURE_COUNTERS = 6'h0c;
	localparam logic [ADDR_W-1:0] OFS_CFG_STAT = 6'h1c;
	localparam logic [ADDR_W-1:0] OFS_RD_CAPT = 6'h20;
	localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 6'h24;
	localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 6'h28;

	localparam int UTM_ID_LSB = 0;
	localparam int UTM_FLAG_BIT = 8;
	localparam int NOACT_ID_LSB = 16;
	localparam int NOACT_FLAG_BIT = 24;
	localparam int BUSY_ID_LSB = 0;
	localparam int BUSY_FLAG_BIT = 8;
	localparam int CNT_NOACT_LSB = 24;
	localparam int CNT_UTM_LSB = 16;
	localparam int CNT_BUSY_LSB = 8;
	localparam int IN_PROG_BIT = 0;
	localparam int RD_ERR_BIT = 1;

	localparam int IRQ_UTM = 0;
	localparam int IRQ_NOACT = 1;
	localparam int IRQ_BUSY = 2;
	localparam int IRQ_RD_ERR = 3;

	localparam logic [DATA_W-1:0] BUSY_CLEAR_VAL = 32'hffffffff;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		RAM_REG_ERR_DROP = 3'h0,
		RAM_REG_BUSY_ERR = 3'h1,
		RAM_REG_FAILURE_COUNTERS = 3'h2,
		RAM_REG_CFG_STAT = 3'h3,
		RAM_REG_RD_CAPT = 3'h4,
		RAM_REG_IRQ_STAT = 3'h5,
		RAM_REG_IRQ_MASK = 3'h6,
		RAM_REG_NONE = 3'h7
	} ram_reg_e;
endpackage

// [ram_error_monitor.sv]
// Purpose: error tracking and access status at the origin of the configuration bus
// Assumes: event inputs come from logic on ref_clk_i, one-cycle pulses
// Notes: registers reached over AXI4-Lite; one level interrupt output
//
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/1ns
module ram_error_monitor (
	input wire logic ref_clk_i,
	input wire logic rstn_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [31:0] s_axi_awaddr_i,
	input wire logic [2:0] s_axi_awprot_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	output logic [1:0] s_axi_bresp_o,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	input wire logic [31:0] s_axi_araddr_i,
	input wire logic [2:0] s_axi_arprot_i,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	input wire logic unknown_target_evt_i,
	input wire logic [7:0] unknown_target_id_i,
	input wire logic ignored_request_evt_i,
	input wire logic [7:0] ignored_request_target_id_i,
	input wire logic target_busy_evt_i,
	input wire logic [7:0] busy_target_id_i,
	input wire logic acc_start_i,
	input wire logic acc_is_read_i,
	input wire logic wr_done_i,
	input wire logic rd_done_i,
	input wire logic [31:0] rd_data_i,
	output logic access_in_progress_o,
	output logic irq_o
);

	typedef struct packed {
		logic aw_full;
		logic [ram_pkg::ADDR_W-1:0] aw_addr;
		logic w_full;
		logic [ram_pkg::DATA_W-1:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [ram_pkg::DATA_W-1:0] rdata;
		logic [1:0] rresp;
		logic utm_flag;
		logic [ram_pkg::ID_W-1:0] unknown_target_id;
		logic noact_flag;
		logic [ram_pkg::ID_W-1:0] ignored_request_target_id;
		logic busy_flag;
		logic [ram_pkg::ID_W-1:0] busy_target_id;
		logic [ram_pkg::CNT_W-1:0] ignored_request_count;
		logic [ram_pkg::CNT_W-1:0] unknown_target_count;
		logic [ram_pkg::CNT_W-1:0] target_busy_count;
		logic rd_err;
		logic [ram_pkg::ACC_CNT_W-1:0] acc_cnt;
		logic [ram_pkg::ACC_CNT_W-1:0] rd_cnt;
		logic [ram_pkg::DATA_W-1:0] rd_capt;
		logic [ram_pkg::IRQ_W-1:0] irq_stat;
		logic [ram_pkg::IRQ_W-1:0] irq_mask;
	} ram_state_s;

	ram_state_s s;
	ram_state_s next_s;

	function automatic ram_pkg::ram_reg_e decode(input logic [ram_pkg::ADDR_W-1:0] a);
		ram_pkg::ram_reg_e r;
		unique case (a)
			ram_pkg::OFS_ERR_DROP: r = ram_pkg::RAM_REG_ERR_DROP;
			ram_pkg::OFS_BUSY_ERR: r = ram_pkg::RAM_REG_BUSY_ERR;
			ram_pkg::OFS_FAILURE_COUNTERS: r = ram_pkg::RAM_REG_FAILURE_COUNTERS;
			ram_pkg::OFS_CFG_STAT: r = ram_pkg::RAM_REG_CFG_STAT;
			ram_pkg::OFS_RD_CAPT: r = ram_pkg::RAM_REG_RD_CAPT;
			ram_pkg::OFS_IRQ_STAT: r = ram_pkg::RAM_REG_IRQ_STAT;
			ram_pkg::OFS_IRQ_MASK: r = ram_pkg::RAM_REG_IRQ_MASK;
			default: r = ram_pkg::RAM_REG_NONE;
		endcase
		return r;
	endfunction

	function automatic logic [ram_pkg::DATA_W-1:0] read_word(input ram_pkg::ram_reg_e r,
		input ram_state_s st);
		logic [ram_pkg::DATA_W-1:0] d;
		d = '0;
		unique case (r)
			ram_pkg::RAM_REG_ERR_DROP: begin
				d[ram_pkg::UTM_ID_LSB +: ram_pkg::ID_W] = st.unknown_target_id;
				d[ram_pkg::UTM_FLAG_BIT] = st.utm_flag;
				d[ram_pkg::NOACT_ID_LSB +: ram_pkg::ID_W] = st.ignored_request_target_id;
				d[ram_pkg::NOACT_FLAG_BIT] = st.noact_flag;
			end
			ram_pkg::RAM_REG_BUSY_ERR: begin
				d[ram_pkg::BUSY_ID_LSB +: ram_pkg::ID_W] = st.busy_target_id;
				d[ram_pkg::BUSY_FLAG_BIT] = st.busy_flag;
			end
			ram_pkg::RAM_REG_FAILURE_COUNTERS: begin
				d[ram_pkg::CNT_NOACT_LSB +: ram_pkg::CNT_W] = st.ignored_request_count;
				d[ram_pkg::CNT_UTM_LSB +: ram_pkg::CNT_W] = st.unknown_target_count;
				d[ram_pkg::CNT_BUSY_LSB +: ram_pkg::CNT_W] = st.target_busy_count;
			end
			ram_pkg::RAM_REG_CFG_STAT: begin
				d[ram_pkg::IN_PROG_BIT] = (st.acc_cnt != '0);
				d[ram_pkg::RD_ERR_BIT] = st.rd_err;
			end
			ram_pkg::RAM_REG_RD_CAPT: d = st.rd_capt;
			ram_pkg::RAM_REG_IRQ_STAT: d[ram_pkg::IRQ_W-1:0] = st.irq_stat;
			ram_pkg::RAM_REG_IRQ_MASK: d[ram_pkg::IRQ_W-1:0] = st.irq_mask;
			ram_pkg::RAM_REG_NONE: d = '0;
		endcase
		return d;
	endfunction

	function automatic logic [ram_pkg::DATA_W-1:0] lane_mask(input logic [3:0] strb);
		logic [ram_pkg::DATA_W-1:0] m;
		m = '0;
		for (int i = 0; i < 4; i++) begin
			m[i*8 +: 8] = {8{strb[i]}};
		end
		return m;
	endfunction

	// saturate instead of wrapping so a flood of errors never reads as few
	function automatic logic [ram_pkg::CNT_W-1:0] sat_inc(input logic [ram_pkg::CNT_W-1:0] v);
		return (&v) ? v : v + 1'b1; // R9
	endfunction

	ram_pkg::ram_reg_e wr_sel;
	logic do_wr;
	logic [ram_pkg::DATA_W-1:0] wmask;
	logic [ram_pkg::DATA_W-1:0] wbits;
	logic [ram_pkg::DATA_W-1:0] merged;
	logic rd_overlap;

	assign s_axi_awready_o = !s.aw_full;
	assign s_axi_wready_o = !s.w_full;
	assign s_axi_bvalid_o = s.bvalid;
	assign s_axi_bresp_o = s.bresp;
	assign s_axi_arready_o = !s.rvalid;
	assign s_axi_rvalid_o = s.rvalid;
	assign s_axi_rdata_o = s.rdata;
	assign s_axi_rresp_o = s.rresp;
	assign access_in_progress_o = (s.acc_cnt != '0); // R12
	assign irq_o = |(s.irq_stat & s.irq_mask);

	always_comb begin
		wr_sel = decode(s.aw_addr);
		do_wr = s.aw_full && s.w_full && !s.bvalid;
		wmask = lane_mask(s.w_strb);
		wbits = s.w_data & wmask;
		merged = (read_word(wr_sel, s) & ~wmask) | wbits;
		// a previous read finishing in this very cycle is not an overlap
		rd_overlap = acc_start_i && acc_is_read_i &&
			(s.rd_cnt > ram_pkg::ACC_CNT_W'(rd_done_i)); // R10
		next_s = s;

		if (s_axi_awvalid_i && !s.aw_full) begin
			next_s.aw_full = 1'b1;
			next_s.aw_addr = s_axi_awaddr_i[ram_pkg::ADDR_W-1:0];
		end
		if (s_axi_wvalid_i && !s.w_full) begin
			next_s.w_full = 1'b1;
			next_s.w_data = s_axi_wdata_i;
			next_s.w_strb = s_axi_wstrb_i;
		end
		if (s.bvalid && s_axi_bready_i) begin
			next_s.bvalid = 1'b0;
		end
		if (do_wr) begin
			next_s.aw_full = 1'b0;
			next_s.w_full = 1'b0;
			next_s.bvalid = 1'b1;
			next_s.bresp = (wr_sel == ram_pkg::RAM_REG_NONE) ?
				ram_pkg::RESP_SLVERR : ram_pkg::RESP_OKAY;
		end

		if (s.rvalid && s_axi_rready_i) begin
			next_s.rvalid = 1'b0;
		end
		if (s_axi_arvalid_i && !s.rvalid) begin
			next_s.rvalid = 1'b1;
			next_s.rdata = read_word(decode(s_axi_araddr_i[ram_pkg::ADDR_W-1:0]), s);
			next_s.rresp = (decode(s_axi_araddr_i[ram_pkg::ADDR_W-1:0]) ==
				ram_pkg::RAM_REG_NONE) ? ram_pkg::RESP_SLVERR : ram_pkg::RESP_OKAY;
		end

		// software effects first; hardware events below override them
		if (do_wr) begin
			unique case (wr_sel)
				ram_pkg::RAM_REG_ERR_DROP: begin
					if (wbits[ram_pkg::UTM_FLAG_BIT]) begin
						next_s.utm_flag = 1'b0; // R14
						next_s.unknown_target_id = '0;
					end
					if (wbits[ram_pkg::NOACT_FLAG_BIT]) begin
						next_s.noact_flag = 1'b0; // R14
						next_s.ignored_request_target_id = '0;
					end
				end
				ram_pkg::RAM_REG_BUSY_ERR: begin
					if (wbits == ram_pkg::BUSY_CLEAR_VAL) begin
						next_s.busy_flag = 1'b0; // R5
						next_s.busy_target_id = '0; // R5
					end
				end
				ram_pkg::RAM_REG_FAILURE_COUNTERS: begin
					next_s.ignored_request_count =
						merged[ram_pkg::CNT_NOACT_LSB +: ram_pkg::CNT_W]; // R14
					next_s.unknown_target_count =
						merged[ram_pkg::CNT_UTM_LSB +: ram_pkg::CNT_W]; // R14
					next_s.target_busy_count =
						merged[ram_pkg::CNT_BUSY_LSB +: ram_pkg::CNT_W]; // R14
				end
				ram_pkg::RAM_REG_CFG_STAT: begin
					if (wbits[ram_pkg::RD_ERR_BIT]) begin
						next_s.rd_err = 1'b0;
					end
				end
				ram_pkg::RAM_REG_IRQ_STAT: begin
					next_s.irq_stat = s.irq_stat & ~wbits[ram_pkg::IRQ_W-1:0];
				end
				ram_pkg::RAM_REG_IRQ_MASK: begin
					next_s.irq_mask = merged[ram_pkg::IRQ_W-1:0];
				end
				ram_pkg::RAM_REG_RD_CAPT, ram_pkg::RAM_REG_NONE: begin
				end
			endcase
		end

		if (unknown_target_evt_i) begin
			next_s.utm_flag = 1'b1; // R1
			next_s.unknown_target_id = unknown_target_id_i; // R1
			next_s.unknown_target_count = sat_inc(next_s.unknown_target_count); // R7
			next_s.irq_stat[ram_pkg::IRQ_UTM] = 1'b1;
		end
		if (ignored_request_evt_i) begin
			next_s.noact_flag = 1'b1; // R2
			next_s.ignored_request_target_id = ignored_request_target_id_i; // R2
			next_s.ignored_request_count = sat_inc(next_s.ignored_request_count); // R6
			next_s.irq_stat[ram_pkg::IRQ_NOACT] = 1'b1;
		end
		if (target_busy_evt_i) begin
			next_s.busy_flag = 1'b1; // R3
			next_s.busy_target_id = busy_target_id_i; // R4
			next_s.target_busy_count = sat_inc(next_s.target_busy_count); // R8
			next_s.irq_stat[ram_pkg::IRQ_BUSY] = 1'b1;
		end
		if (rd_overlap) begin
			next_s.rd_err = 1'b1; // R10
			next_s.irq_stat[ram_pkg::IRQ_RD_ERR] = 1'b1;
		end

		// both overlapping reads stay counted; each completion overwrites capture
		if (rd_done_i) begin
			next_s.rd_capt = rd_data_i; // R11
		end
		next_s.rd_cnt = s.rd_cnt + ram_pkg::ACC_CNT_W'(acc_start_i && acc_is_read_i)
			- ram_pkg::ACC_CNT_W'(rd_done_i && (s.rd_cnt != '0)); // R11
		next_s.acc_cnt = s.acc_cnt + ram_pkg::ACC_CNT_W'(acc_start_i)
			- ram_pkg::ACC_CNT_W'((rd_done_i || wr_done_i) && (s.acc_cnt != '0)); // R12
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rstn_i) begin
			s <= '0; // R13
		end else begin
			s <= next_s;
		end
	end

endmodule // ram_error_monitor

// [ram_error_monitor_properties.sv]
// Purpose: port-level properties of the error monitor
// Assumes: single clock, synchronous active-low reset
// Notes: attached by bind at the foot of this file
`timescale 1ns/1ns
module ram_error_monitor_properties (
	input wire logic ref_clk_i,
	input wire logic rstn_i,
	input wire logic s_axi_awvalid_i,
	input wire logic s_axi_awready_o,
	input wire logic s_axi_wvalid_i,
	input wire logic s_axi_wready_o,
	input wire logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	input wire logic s_axi_arvalid_i,
	input wire logic s_axi_arready_o,
	input wire logic [31:0] s_axi_araddr_i,
	input wire logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	input wire logic [31:0] s_axi_rdata_o,
	input wire logic [1:0] s_axi_rresp_o,
	input wire logic acc_start_i,
	input wire logic wr_done_i,
	input wire logic rd_done_i,
	input wire logic access_in_progress_o,
	input wire logic irq_o
);
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!rstn_i);
	rdata_hold_a: assert property (s_axi_rvalid_o && !s_axi_rready_i
		|=> s_axi_rvalid_o && $stable(s_axi_rdata_o)) else $error("read answer dropped");
	bresp_hold_a: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o)
		else $error("write answer dropped");
	read_block_a: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
		else $error("address taken while answer pending");
	write_answer_a: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i
		&& s_axi_wready_o |-> ##2 s_axi_bvalid_o) else $error("write answer late");
	bad_read_a: assert property (s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i[5:0] == 6'h04
		|=> s_axi_rvalid_o && s_axi_rresp_o == 2'h2 && s_axi_rdata_o == 32'h0)
		else $error("unmapped read not refused");
	access_busy_a: assert property (acc_start_i && !wr_done_i && !rd_done_i
		|=> access_in_progress_o) else $error("in-progress flag missing");
	access_idle_a: assert property (!access_in_progress_o && !acc_start_i
		|=> !access_in_progress_o) else $error("in-progress flag without access");
	reset_clear_a: assert property ($rose(rstn_i) |-> !irq_o && !access_in_progress_o)
		else $error("state not cleared by reset");
endmodule // ram_error_monitor_properties

bind ram_error_monitor ram_error_monitor_properties chk (.ref_clk_i, .rstn_i, .s_axi_awvalid_i,
	.s_axi_awready_o, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bvalid_o, .s_axi_bready_i,
	.s_axi_arvalid_i, .s_axi_arready_o, .s_axi_araddr_i, .s_axi_rvalid_o, .s_axi_rready_i,
	.s_axi_rdata_o, .s_axi_rresp_o, .acc_start_i, .wr_done_i, .rd_done_i,
	.access_in_progress_o, .irq_o);

// [ram_far_model.sv]
// Purpose: targets and access master seen from the monitor
// Assumes: strobes last one cycle and change right after a rising edge
// Notes: released id and data lines show the inverse of the last value
`timescale 1ns/1ns
module ram_far_model (
	input wire logic clk_i,
	output logic [2:0] evt_o,
	output logic [7:0] id_o,
	output logic start_o,
	output logic is_read_o,
	output logic wr_done_o,
	output logic rd_done_o,
	output logic [31:0] rd_data_o
);
	initial begin
		{evt_o, start_o, is_read_o, wr_done_o, rd_done_o} = 7'h00;
		id_o = 8'h00;
		rd_data_o = 32'h0;
	end
	// rd bit0 starts a read, bit1 completes one
	task automatic strobe(input logic [2:0] e, input logic [7:0] id, input logic [1:0] rd,
		input logic [31:0] d);
		@(posedge clk_i);
		evt_o <= e;
		id_o <= id;
		{start_o, is_read_o} <= {2{rd[0]}};
		rd_done_o <= rd[1];
		rd_data_o <= d;
		@(posedge clk_i);
		{evt_o, start_o, is_read_o, rd_done_o} <= 6'h00;
		id_o <= ~id;
		rd_data_o <= ~d;
	endtask
endmodule // ram_far_model

// [test_ram_error_monitor.sv]
// Purpose: register-level test of the error monitor
// Assumes: AXI4-Lite master tasks, far side driven by the model
// Notes: expectations follow the register layout only
`timescale 1ns/1ns
module test_ram_error_monitor;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
	logic [31:0] awa = 32'h0, wd = 32'h0, ara = 32'h0;
	wire logic awr, wrr, bv, arr, rv, irq, st, isrd, wrd, rdd, aip;
	wire logic [1:0] br, rr;
	wire logic [2:0] evt;
	wire logic [7:0] id;
	wire logic [31:0] rd_q, rdat;
	int mismatches = 0;
	int checks_done = 0;
	logic [31:0] d;
	logic [1:0] r;
	always #25 clk = ~clk;
	ram_far_model far (.clk_i(clk), .evt_o(evt), .id_o(id), .start_o(st), .is_read_o(isrd),
		.wr_done_o(wrd), .rd_done_o(rdd), .rd_data_o(rdat));
	ram_error_monitor uut (.ref_clk_i(clk), .rstn_i(rstn), .s_axi_awvalid_i(awv),
		.s_axi_awready_o(awr), .s_axi_awaddr_i(awa), .s_axi_awprot_i(3'h0),
		.s_axi_wvalid_i(wv), .s_axi_wready_o(wrr), .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hf),
		.s_axi_bvalid_o(bv), .s_axi_bready_i(bre), .s_axi_bresp_o(br), .s_axi_arvalid_i(arv),
		.s_axi_arready_o(arr), .s_axi_araddr_i(ara), .s_axi_arprot_i(3'h0),
		.s_axi_rvalid_o(rv), .s_axi_rready_i(rre), .s_axi_rdata_o(rd_q), .s_axi_rresp_o(rr),
		.unknown_target_evt_i(evt[0]), .unknown_target_id_i(id),
		.ignored_request_evt_i(evt[1]), .ignored_request_target_id_i(id),
		.target_busy_evt_i(evt[2]), .busy_target_id_i(id), .acc_start_i(st),
		.acc_is_read_i(isrd), .wr_done_i(wrd), .rd_done_i(rdd), .rd_data_i(rdat),
		.access_in_progress_o(aip), .irq_o(irq));
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [5:0] a, input logic [31:0] v);
		logic pa;
		logic pd;
		@(posedge clk);
		{awv, wv} <= 2'h3;
		awa <= {26'h0, a};
		wd <= v;
		{pa, pd} = 2'h3;
		while (pa || pd) begin
			@(posedge clk);
			if (pa && awr) begin
				pa = 1'b0;
				awv <= 1'b0;
			end
			if (pd && wrr) begin
				pd = 1'b0;
				wv <= 1'b0;
			end
		end
		bre <= 1'b1;
		do @(posedge clk); while (bv !== 1'b1);
		r = br;
		bre <= 1'b0;
	endtask
	task automatic rd(input logic [5:0] a);
		@(posedge clk);
		{arv, rre} <= 2'h3;
		ara <= {26'h0, a};
		do @(posedge clk); while (arr !== 1'b1);
		arv <= 1'b0;
		do @(posedge clk); while (rv !== 1'b1);
		{d, r} = {rd_q, rr};
		rre <= 1'b0;
	endtask
	task automatic rchk(input string n, input logic [5:0] a, input logic [31:0] e);
		rd(a);
		chk(n, e, d);
		chk("rresp", 32'h0, {30'h0, r});
	endtask
	task automatic give_verdict;
		if (mismatches == 0 && checks_done > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		mismatches++;
		give_verdict;
	end
	initial begin
		repeat (10) @(posedge clk);
		rstn <= 1'b1;
		rchk("drop0", ram_pkg::OFS_ERR_DROP, 32'h0);
		rchk("busy0", ram_pkg::OFS_BUSY_ERR, 32'h0);
		rchk("cnts0", ram_pkg::OFS_FAILURE_COUNTERS, 32'h0);
		rchk("stat0", ram_pkg::OFS_CFG_STAT, 32'h0);
		far.strobe(3'h1, 8'h5a, 2'h0, 32'h0);
		rchk("unknown", ram_pkg::OFS_ERR_DROP, 32'h0000015a);
		far.strobe(3'h2, 8'h33, 2'h0, 32'h0);
		rchk("ignored", ram_pkg::OFS_ERR_DROP, 32'h0133015a);
		far.strobe(3'h4, 8'h11, 2'h0, 32'h0);
		far.strobe(3'h4, 8'h22, 2'h0, 32'h0);
		rchk("busy", ram_pkg::OFS_BUSY_ERR, 32'h00000122);
		rchk("counts", ram_pkg::OFS_FAILURE_COUNTERS, 32'h01010200);
		wr(ram_pkg::OFS_BUSY_ERR, 32'h00000100);
		rchk("busy_kept", ram_pkg::OFS_BUSY_ERR, 32'h00000122);
		wr(ram_pkg::OFS_BUSY_ERR, 32'hffffffff);
		rchk("busy_clr", ram_pkg::OFS_BUSY_ERR, 32'h0);
		wr(ram_pkg::OFS_FAILURE_COUNTERS, 32'hfefefe00);
		far.strobe(3'h7, 8'h01, 2'h0, 32'h0);
		far.strobe(3'h7, 8'h01, 2'h0, 32'h0);
		far.strobe(3'h7, 8'h01, 2'h0, 32'h0);
		rchk("saturate", ram_pkg::OFS_FAILURE_COUNTERS, 32'hffffff00);
		chk("irq_masked", 32'h0, {31'h0, irq});
		wr(ram_pkg::OFS_IRQ_MASK, 32'h4);
		chk("irq_on", 32'h1, {31'h0, irq});
		far.strobe(3'h0, 8'h00, 2'h1, 32'h0);
		far.strobe(3'h0, 8'h00, 2'h1, 32'h0);
		rchk("overlap", ram_pkg::OFS_CFG_STAT, 32'h3);
		chk("in_progress", 32'h1, {31'h0, aip});
		far.strobe(3'h0, 8'h00, 2'h2, 32'h0000aaaa);
		far.strobe(3'h0, 8'h00, 2'h2, 32'h00005555);
		rchk("idle", ram_pkg::OFS_CFG_STAT, 32'h2);
		chk("no_access", 32'h0, {31'h0, aip});
		rchk("latest", ram_pkg::OFS_RD_CAPT, 32'h00005555);
		rchk("irq_stat", ram_pkg::OFS_IRQ_STAT, 32'hf);
		wr(ram_pkg::OFS_IRQ_STAT, 32'hf);
		chk("irq_off", 32'h0, {31'h0, irq});
		rd(6'h04);
		chk("bad_rresp", 32'h2, {30'h0, r});
		chk("bad_rdata", 32'h0, d);
		wr(6'h04, 32'h1);
		chk("bad_bresp", 32'h2, {30'h0, r});
		rchk("sticky", ram_pkg::OFS_ERR_DROP, 32'h01010101);
		give_verdict;
	end
endmodule // test_ram_error_monitor
